//--- uart_channel.sv
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// RQ1: Transmit path is a 64-byte FIFO, holding register and 8-bit shift register.
// RQ2: FIFO enable clear loads holding from host writes; set loads it from FIFO.
// RQ3: Shift register advances one bit per 16 or 8 oversampling clocks.
// RQ4: Frame is start, data bits, optional parity, then configured stop bits.
// RQ5: Line status bit 5 shows holding empty, bit 6 shows shifter empty.
// RQ6: Extended bits act only while enhanced function bit 4 is set; the turnaround delay here keeps acting after that bit is cleared.
// RQ7: Modem control bits 2 and 3 drive no pins, only loopback feedback; bit 2 here still moves auto direction control to dtr_n.
// RQ8: Divisor bytes reachable only with line control bit 7; form 16-bit rate.
// RQ9: Loopback routes shifter to receiver, holds transmit high, ignores modem pins; auto CTS here still waits on the cts_n pin.
// RQ10: Auto direction control drops direction after last stop plus programmed delay.
// RQ11: Infrared mode sends a 3/16 bit pulse per zero bit in 16x mode, a 2/8 bit pulse in 8x mode, none per one.
// RQ12: Reads and writes at one offset reach different registers; bit 7 selects divisor.
module uart_channel #(
	parameter int TX_DEPTH = 64
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic resetn,
	// Register port.
	input wire uart_channel_pkg::reg_req_s req,
	output logic [7:0] rdata,
	output logic tx_space,
	// Oversampling mode.
	input wire logic eight_x_mode,
	// Serial and modem pins, modem lines active low.
	output logic tx_pin,
	output logic rts_n,
	output logic dtr_n,
	input wire logic cts_n,
	input wire logic dsr_n,
	input wire logic cd_n,
	input wire logic ri_n,
	// Receiver side.
	input wire uart_channel_pkg::rx_status_s rx_status,
	output logic rx_pop,
	output logic rx_fifo_reset,
	output logic sample_tick,
	output logic loop_data,
	output uart_channel_pkg::rx_config_s rx_config
);

	// ****************************************************************
	// Configuration registers.
	// ****************************************************************
	logic [7:0] line_control;
	logic [7:0] modem_control;
	logic [7:0] interrupt_enable;
	logic [7:0] divisor_low;
	logic [7:0] divisor_high;
	logic [7:0] scratch;
	logic [7:0] feature_control;
	logic [7:0] enhanced_function;
	logic [7:0] tx_trigger_level;
	logic [7:0] rx_trigger_level;
	logic [7:0] stop_char_1;
	logic [7:0] stop_char_2;
	logic [7:0] resume_char_1;
	logic [7:0] resume_char_2;
	logic [3:0] turnaround_delay;
	logic [1:0] tx_trigger_select;
	logic [1:0] rx_trigger_select;
	logic fifo_enable;
	logic tx_flush;

	logic ext_en;
	logic dlab;
	logic wr;
	logic [7:0] ien_eff;
	logic [7:0] mc_eff;

	assign ext_en = enhanced_function[uart_channel_pkg::ENH_EXT];
	assign dlab = line_control[uart_channel_pkg::LC_DLAB];
	assign wr = req.wr;
	assign ien_eff = ext_en ? interrupt_enable :
		(interrupt_enable & ~uart_channel_pkg::EXT_MASK_IEN); // RQ6
	assign mc_eff = ext_en ? modem_control :
		(modem_control & ~uart_channel_pkg::EXT_MASK_MC); // RQ6

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			line_control <= uart_channel_pkg::RESET_BYTE;
			modem_control <= uart_channel_pkg::RESET_BYTE;
			interrupt_enable <= uart_channel_pkg::RESET_BYTE;
			divisor_low <= uart_channel_pkg::RESET_BYTE;
			divisor_high <= uart_channel_pkg::RESET_BYTE;
			scratch <= uart_channel_pkg::RESET_BYTE;
			feature_control <= uart_channel_pkg::RESET_BYTE;
			enhanced_function <= uart_channel_pkg::RESET_BYTE;
			tx_trigger_level <= uart_channel_pkg::RESET_BYTE;
			rx_trigger_level <= uart_channel_pkg::RESET_BYTE;
			stop_char_1 <= uart_channel_pkg::RESET_BYTE;
			stop_char_2 <= uart_channel_pkg::RESET_BYTE;
			resume_char_1 <= uart_channel_pkg::RESET_BYTE;
			resume_char_2 <= uart_channel_pkg::RESET_BYTE;
			turnaround_delay <= '0;
			tx_trigger_select <= '0;
			rx_trigger_select <= '0;
			fifo_enable <= 1'b0;
			tx_flush <= 1'b0;
			rx_fifo_reset <= 1'b0;
		end else begin
			tx_flush <= 1'b0;
			rx_fifo_reset <= 1'b0;
			if (wr) begin
				if (req.addr == uart_channel_pkg::ADDR_DATA && dlab) begin
					divisor_low <= req.wdata; // RQ8 RQ12
				end else if (req.addr == uart_channel_pkg::ADDR_IEN && dlab) begin
					divisor_high <= req.wdata; // RQ8 RQ12
				end else if (req.addr == uart_channel_pkg::ADDR_IEN) begin
					interrupt_enable <= req.wdata; // RQ12
				end else if (req.addr == uart_channel_pkg::ADDR_FIFO) begin
					fifo_enable <= req.wdata[uart_channel_pkg::FC_FIFO_EN];
					rx_trigger_select <= req.wdata[7:6];
					if (ext_en) begin
						tx_trigger_select <= req.wdata[5:4]; // RQ6
					end
					// Switching modes flushes so stale bytes never leak across.
					tx_flush <= req.wdata[uart_channel_pkg::FC_TX_RESET] ||
						(req.wdata[uart_channel_pkg::FC_FIFO_EN] != fifo_enable);
					rx_fifo_reset <= req.wdata[1];
				end else if (req.addr == uart_channel_pkg::ADDR_LCTL) begin
					line_control <= req.wdata;
				end else if (req.addr == uart_channel_pkg::ADDR_MCTL) begin
					modem_control <= req.wdata;
				end else if (req.addr == uart_channel_pkg::ADDR_MSTAT) begin
					if (ext_en) begin
						turnaround_delay <= req.wdata[7:4]; // RQ6 RQ10
					end
				end else if (req.addr == uart_channel_pkg::ADDR_SCRATCH) begin
					scratch <= req.wdata;
				end else if (req.addr == uart_channel_pkg::ADDR_FEAT) begin
					feature_control <= req.wdata;
				end else if (req.addr == uart_channel_pkg::ADDR_ENH) begin
					enhanced_function <= req.wdata;
				end else if (req.addr == uart_channel_pkg::ADDR_TXLVL) begin
					tx_trigger_level <= req.wdata;
				end else if (req.addr == uart_channel_pkg::ADDR_RXLVL) begin
					rx_trigger_level <= req.wdata;
				end else if (req.addr == uart_channel_pkg::ADDR_FLOW) begin
					stop_char_1 <= req.wdata;
				end else if (req.addr == uart_channel_pkg::ADDR_STOP2) begin
					stop_char_2 <= req.wdata;
				end else if (req.addr == uart_channel_pkg::ADDR_RES1) begin
					resume_char_1 <= req.wdata;
				end else if (req.addr == uart_channel_pkg::ADDR_RES2) begin
					resume_char_2 <= req.wdata;
				end
			end
		end
	end

	// ****************************************************************
	// Baud generator: one oversampling tick per divisor count.
	// ****************************************************************
	logic [15:0] divisor;
	logic [15:0] baud_cnt;

	assign divisor = {divisor_high, divisor_low}; // RQ8

	// A zero divisor stops the ticks rather than running at clock rate.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			baud_cnt <= '0;
			sample_tick <= 1'b0;
		end else if (divisor == '0) begin
			baud_cnt <= '0;
			sample_tick <= 1'b0;
		end else if (baud_cnt >= divisor - 16'h0001) begin
			baud_cnt <= '0;
			sample_tick <= 1'b1; // RQ8
		end else begin
			baud_cnt <= baud_cnt + 16'h0001;
			sample_tick <= 1'b0;
		end
	end

	// ****************************************************************
	// Transmit FIFO and holding register.
	// ****************************************************************
	localparam int LW = $clog2(TX_DEPTH+1);
	logic host_data_wr;
	logic fifo_out_valid;
	logic fifo_pop;
	logic [7:0] fifo_out_data;
	logic [LW-1:0] fifo_level;
	logic fifo_in_ready;
	logic [7:0] holding;
	logic hold_full;
	logic load_shift;

	assign host_data_wr = wr && req.addr == uart_channel_pkg::ADDR_DATA && !dlab; // RQ12
	assign fifo_pop = fifo_enable && !hold_full; // RQ2
	assign tx_space = fifo_enable ? fifo_in_ready : 1'b1;

	tx_byte_fifo #(
		.WIDTH(8),
		.DEPTH(TX_DEPTH)
	) u_tx_fifo ( // RQ1
		.clk(clk),
		.resetn(resetn),
		.flush(tx_flush),
		.in_valid(host_data_wr && fifo_enable),
		.in_ready(fifo_in_ready),
		.in_data(req.wdata),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data),
		.level(fifo_level)
	);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			holding <= '0;
			hold_full <= 1'b0;
		end else if (tx_flush) begin
			hold_full <= 1'b0;
		end else if (!fifo_enable && host_data_wr) begin
			holding <= req.wdata; // RQ2
			hold_full <= 1'b1;
		end else if (fifo_pop && fifo_out_valid) begin
			holding <= fifo_out_data; // RQ2
			hold_full <= 1'b1;
		end else if (load_shift) begin
			hold_full <= 1'b0;
		end
	end

	// ****************************************************************
	// Shift register and frame sequencer.
	// ****************************************************************
	uart_channel_pkg::tx_state_e state;
	logic [7:0] tx_shift_register;
	logic [3:0] os_cnt;
	logic [3:0] os_last;
	logic [2:0] bit_idx;
	logic par_acc;
	logic stop_idx;
	logic line_bit;
	logic bit_end;
	logic cts_ok;
	logic parity_bit;

	assign os_last = eight_x_mode ? uart_channel_pkg::OS_LAST_8X : uart_channel_pkg::OS_LAST_16X;
	assign bit_end = sample_tick && os_cnt == os_last; // RQ3
	assign cts_ok = !enhanced_function[uart_channel_pkg::ENH_AUTO_CTS] || !cts_n;
	assign load_shift = state == uart_channel_pkg::TX_IDLE && hold_full && cts_ok;
	assign parity_bit = line_control[uart_channel_pkg::LC_FORCE_PAR] ?
		!line_control[uart_channel_pkg::LC_EVEN_PAR] :
		(par_acc ^ !line_control[uart_channel_pkg::LC_EVEN_PAR]);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= uart_channel_pkg::TX_IDLE;
			tx_shift_register <= '0;
			os_cnt <= '0;
			bit_idx <= '0;
			par_acc <= 1'b0;
			stop_idx <= 1'b0;
			line_bit <= 1'b1;
		end else begin
			if (load_shift) begin
				os_cnt <= '0;
			end else if (sample_tick) begin
				os_cnt <= (os_cnt == os_last) ? '0 : os_cnt + 4'h1; // RQ3
			end
			case (state)
				uart_channel_pkg::TX_IDLE: begin
					line_bit <= 1'b1;
					if (load_shift) begin
						tx_shift_register <= holding; // RQ1
						state <= uart_channel_pkg::TX_START;
						line_bit <= 1'b0; // RQ4
					end
				end
				uart_channel_pkg::TX_START: begin
					if (bit_end) begin
						state <= uart_channel_pkg::TX_DATA;
						line_bit <= tx_shift_register[0];
						par_acc <= tx_shift_register[0];
						tx_shift_register <= tx_shift_register >> 1;
						bit_idx <= '0;
					end
				end
				uart_channel_pkg::TX_DATA: begin
					if (bit_end) begin
						if (bit_idx == {1'b1, line_control[1:0]}) begin
							stop_idx <= 1'b0;
							if (line_control[uart_channel_pkg::LC_PAR_EN]) begin
								state <= uart_channel_pkg::TX_PARITY; // RQ4
								line_bit <= parity_bit;
							end else begin
								state <= uart_channel_pkg::TX_STOP;
								line_bit <= 1'b1;
							end
						end else begin
							bit_idx <= bit_idx + 3'h1;
							line_bit <= tx_shift_register[0]; // RQ3
							par_acc <= par_acc ^ tx_shift_register[0];
							tx_shift_register <= tx_shift_register >> 1;
						end
					end
				end
				uart_channel_pkg::TX_PARITY: begin
					if (bit_end) begin
						state <= uart_channel_pkg::TX_STOP;
						line_bit <= 1'b1;
					end
				end
				uart_channel_pkg::TX_STOP: begin
					if (bit_end) begin
						if (line_control[uart_channel_pkg::LC_STOP2] && !stop_idx) begin
							stop_idx <= 1'b1; // RQ4
						end else begin
							state <= uart_channel_pkg::TX_IDLE;
						end
					end
				end
				default: begin
					state <= uart_channel_pkg::TX_IDLE;
				end
			endcase
		end
	end

	// ****************************************************************
	// Status and auto direction control.
	// ****************************************************************
	logic hold_empty;
	logic shift_empty;
	logic dir_active;
	logic [3:0] dly_cnt;
	logic rs485_en;

	assign hold_empty = !hold_full && (!fifo_enable || !fifo_out_valid); // RQ5
	assign shift_empty = hold_empty && state == uart_channel_pkg::TX_IDLE; // RQ5
	assign rs485_en = feature_control[uart_channel_pkg::FEAT_RS485];

	// The delay counts whole bit times so the last stop bit reaches far stations.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dir_active <= 1'b0;
			dly_cnt <= '0;
		end else if (!rs485_en || !shift_empty) begin
			dir_active <= rs485_en;
			dly_cnt <= turnaround_delay;
		end else if (dir_active) begin
			if (dly_cnt == '0) begin
				dir_active <= 1'b0; // RQ10
			end else if (sample_tick && os_cnt == os_last) begin
				dly_cnt <= dly_cnt - 4'h1; // RQ10
			end
		end
	end

	// ****************************************************************
	// Modem lines, loopback and infrared output.
	// ****************************************************************
	logic loopback;
	logic ir_on;
	logic [3:0] ir_width;
	logic [3:0] modem_in;
	logic [3:0] modem_prev;
	logic [3:0] modem_delta;
	logic mstat_read;

	assign loopback = mc_eff[uart_channel_pkg::MC_LOOP];
	assign ir_on = mc_eff[uart_channel_pkg::MC_IR];
	assign ir_width = eight_x_mode ? uart_channel_pkg::IR_WIDTH_8X : uart_channel_pkg::IR_WIDTH_16X;
	assign mstat_read = req.rd && req.addr == uart_channel_pkg::ADDR_MSTAT;
	// Bits 2 and 3 feed back here; bit 2 also steers direction control between rts_n and dtr_n.
	assign modem_in = loopback ?
		{mc_eff[uart_channel_pkg::MC_AUX2], mc_eff[uart_channel_pkg::MC_AUX1_SEL],
		mc_eff[uart_channel_pkg::MC_DTR], mc_eff[uart_channel_pkg::MC_RTS]} :
		{!cd_n, !ri_n, !dsr_n, !cts_n}; // RQ7 RQ9

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_pin <= 1'b1;
			loop_data <= 1'b1;
			rts_n <= 1'b1;
			dtr_n <= 1'b1;
		end else begin
			loop_data <= line_bit; // RQ9
			if (loopback) begin
				tx_pin <= 1'b1; // RQ9
				rts_n <= 1'b1;
				dtr_n <= 1'b1;
			end else begin
				if (ir_on) begin
					tx_pin <= state != uart_channel_pkg::TX_IDLE && !line_bit && os_cnt < ir_width; // RQ11
				end else begin
					tx_pin <= line_bit && !line_control[uart_channel_pkg::LC_BREAK];
				end
				rts_n <= !(mc_eff[uart_channel_pkg::MC_RTS] ||
					(dir_active && !mc_eff[uart_channel_pkg::MC_AUX1_SEL])); // RQ10
				dtr_n <= !(mc_eff[uart_channel_pkg::MC_DTR] ||
					(dir_active && mc_eff[uart_channel_pkg::MC_AUX1_SEL])); // RQ10
			end
		end
	end

	// Deltas are sticky; a change in the read cycle wins over the clear.
	for (genvar i = 0; i < 4; i++) begin : g_modem
		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn) begin
				modem_prev[i] <= 1'b0;
				modem_delta[i] <= 1'b0;
			end else begin
				modem_prev[i] <= modem_in[i];
				if (modem_prev[i] != modem_in[i]) begin
					modem_delta[i] <= 1'b1;
				end else if (mstat_read) begin
					modem_delta[i] <= 1'b0;
				end
			end
		end
	end

	// ****************************************************************
	// Read data path.
	// ****************************************************************
	logic [7:0] next_rdata;

	always_comb begin
		next_rdata = '0;
		if (req.addr == uart_channel_pkg::ADDR_DATA && dlab) begin
			next_rdata = divisor_low; // RQ8
		end else if (req.addr == uart_channel_pkg::ADDR_DATA) begin
			next_rdata = rx_status.data; // RQ12
		end else if (req.addr == uart_channel_pkg::ADDR_IEN && dlab) begin
			next_rdata = divisor_high;
		end else if (req.addr == uart_channel_pkg::ADDR_IEN) begin
			next_rdata = ien_eff;
		end else if (req.addr == uart_channel_pkg::ADDR_FIFO) begin
			next_rdata = {fifo_enable, fifo_enable, uart_channel_pkg::INT_NONE}; // RQ6
		end else if (req.addr == uart_channel_pkg::ADDR_LCTL) begin
			next_rdata = line_control;
		end else if (req.addr == uart_channel_pkg::ADDR_MCTL) begin
			next_rdata = mc_eff;
		end else if (req.addr == uart_channel_pkg::ADDR_LSTAT) begin
			next_rdata = {rx_status.fifo_error, shift_empty, hold_empty,
				rx_status.errors, rx_status.ready}; // RQ5
		end else if (req.addr == uart_channel_pkg::ADDR_MSTAT) begin
			next_rdata = {modem_in, modem_delta};
		end else if (req.addr == uart_channel_pkg::ADDR_SCRATCH) begin
			next_rdata = scratch;
		end else if (req.addr == uart_channel_pkg::ADDR_FEAT) begin
			next_rdata = feature_control;
		end else if (req.addr == uart_channel_pkg::ADDR_ENH) begin
			next_rdata = enhanced_function;
		end else if (req.addr == uart_channel_pkg::ADDR_TXLVL) begin
			next_rdata = 8'(fifo_level);
		end else if (req.addr == uart_channel_pkg::ADDR_RXLVL) begin
			next_rdata = rx_status.level;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata <= '0;
			rx_pop <= 1'b0;
		end else begin
			rx_pop <= req.rd && req.addr == uart_channel_pkg::ADDR_DATA && !dlab;
			if (req.rd) begin
				rdata <= next_rdata;
			end
		end
	end

	assign rx_config = '{line_control: line_control, fifo_enable: fifo_enable,
		trigger_select: rx_trigger_select, trigger_level: rx_trigger_level,
		ir_enable: ir_on, ir_invert: feature_control[uart_channel_pkg::FEAT_IR_INV]};

endmodule : uart_channel
`default_nettype wire

//--- uart_channel_pkg.sv
package uart_channel_pkg;

	// ****************************************************************
	// Register offsets, selected by address bits 3 to 0.
	// ****************************************************************
	localparam logic [3:0] ADDR_DATA = 4'h0;
	localparam logic [3:0] ADDR_IEN = 4'h1;
	localparam logic [3:0] ADDR_FIFO = 4'h2;
	localparam logic [3:0] ADDR_LCTL = 4'h3;
	localparam logic [3:0] ADDR_MCTL = 4'h4;
	localparam logic [3:0] ADDR_LSTAT = 4'h5;
	localparam logic [3:0] ADDR_MSTAT = 4'h6;
	localparam logic [3:0] ADDR_SCRATCH = 4'h7;
	localparam logic [3:0] ADDR_FEAT = 4'h8;
	localparam logic [3:0] ADDR_ENH = 4'h9;
	localparam logic [3:0] ADDR_TXLVL = 4'ha;
	localparam logic [3:0] ADDR_RXLVL = 4'hb;
	localparam logic [3:0] ADDR_FLOW = 4'hc;
	localparam logic [3:0] ADDR_STOP2 = 4'hd;
	localparam logic [3:0] ADDR_RES1 = 4'he;
	localparam logic [3:0] ADDR_RES2 = 4'hf;

	// ****************************************************************
	// Field positions and reset values.
	// ****************************************************************
	localparam int LC_DLAB = 7;
	localparam int LC_BREAK = 6;
	localparam int LC_FORCE_PAR = 5;
	localparam int LC_EVEN_PAR = 4;
	localparam int LC_PAR_EN = 3;
	localparam int LC_STOP2 = 2;
	localparam int MC_IR = 6;
	localparam int MC_LOOP = 4;
	localparam int MC_AUX2 = 3;
	localparam int MC_AUX1_SEL = 2;
	localparam int MC_RTS = 1;
	localparam int MC_DTR = 0;
	localparam int FC_FIFO_EN = 0;
	localparam int FC_TX_RESET = 2;
	localparam int FEAT_RS485 = 5;
	localparam int FEAT_IR_INV = 4;
	localparam int ENH_EXT = 4;
	localparam int ENH_AUTO_CTS = 7;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] EXT_MASK_IEN = 8'he0;
	localparam logic [7:0] EXT_MASK_MC = 8'he4;
	localparam logic [5:0] INT_NONE = 6'h01;

	// ****************************************************************
	// Timing: oversampling clocks per bit and infrared pulse widths.
	// ****************************************************************
	localparam logic [3:0] OS_LAST_16X = 4'hf;
	localparam logic [3:0] OS_LAST_8X = 4'h7;
	localparam logic [3:0] IR_WIDTH_16X = 4'h3;
	localparam logic [3:0] IR_WIDTH_8X = 4'h2;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_START = 3'b001,
		TX_DATA = 3'b010,
		TX_PARITY = 3'b011,
		TX_STOP = 3'b100
	} tx_state_e;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [3:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic [7:0] data;
		logic ready;
		logic [3:0] errors;
		logic fifo_error;
		logic [7:0] level;
	} rx_status_s;

	typedef struct packed {
		logic [7:0] line_control;
		logic fifo_enable;
		logic [1:0] trigger_select;
		logic [7:0] trigger_level;
		logic ir_enable;
		logic ir_invert;
	} rx_config_s;

endpackage : uart_channel_pkg

//--- tx_byte_fifo.sv
`timescale 1ns/10ps
`default_nettype none

module tx_byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic resetn,
	input wire logic flush,
	// Filling side.
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side.
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH+1)-1:0] level
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [CW-1:0] count;
	logic push;
	logic pop;

	assign in_ready = (count != CW'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign level = count;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Depth is expected to be a power of two so the pointers wrap naturally.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else if (flush) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + PW'(1);
			end
			if (pop) begin
				rd_ptr <= rd_ptr + PW'(1);
			end
			if (push && !pop) begin
				count <= count + CW'(1);
			end else if (pop && !push) begin
				count <= count - CW'(1);
			end
		end
	end

endmodule : tx_byte_fifo
`default_nettype wire

//--- uart_channel_chk.sv
`timescale 1ns/10ps
`default_nettype none
module uart_channel_chk (
	// Clock and reset.
	input wire logic clk,
	input wire logic resetn,
	// Observed ports.
	input wire uart_channel_pkg::reg_req_s req,
	input wire logic [7:0] rdata,
	input wire logic tx_space,
	input wire logic tx_pin,
	input wire logic rx_pop,
	input wire logic rx_fifo_reset,
	input wire uart_channel_pkg::rx_config_s rx_config
);
	// ****************
	// Port relations.
	// ****************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	logic rd_data;
	assign rd_data = req.rd && req.addr == 4'h0 && !rx_config.line_control[7];
	a_rdata_hold: assert property (!req.rd |=> $stable(rdata)) else $error("rdata moved");
	a_pop_read: assert property (rd_data |=> rx_pop) else $error("no pop");
	a_pop_cause: assert property (rx_pop |-> $past(rd_data)) else $error("stray pop");
	a_flush_pulse: assert property (req.wr && req.addr == 4'h2 && req.wdata[1]
		|=> rx_fifo_reset ##1 !rx_fifo_reset) else $error("bad flush");
	a_lcr_cfg: assert property (req.wr && req.addr == 4'h3
		|=> rx_config.line_control == $past(req.wdata)) else $error("line control");
	a_fifo_cfg: assert property (req.wr && req.addr == 4'h2
		|=> rx_config.fifo_enable == $past(req.wdata[0])) else $error("fifo en");
	a_space_direct: assert property (!rx_config.fifo_enable |-> tx_space) else $error("space");
	// Six cycles is below the shortest bit, which may lose one tick.
	a_low_width: assert property ($fell(tx_pin) && !rx_config.ir_enable
		|-> !tx_pin [*6]) else $error("short low");
	a_high_width: assert property ($rose(tx_pin) && !rx_config.ir_enable
		|-> tx_pin [*6]) else $error("short high");
	cover property (rx_pop);
	cover property ($fell(tx_pin));
	cover property (rx_fifo_reset);
endmodule : uart_channel_chk
`default_nettype wire

//--- serial_peer.sv
`timescale 1ns/10ps
`default_nettype none
module serial_peer (
	// Clock and line.
	input wire logic clk,
	input wire logic tx_pin,
	// Format and result.
	input wire logic [3:0] nbits,
	input wire logic [4:0] bit_clks,
	output logic [11:0] frame,
	output logic [7:0] n_frames,
	output logic cts_n
);
	// Bits are sampled at their centres, so a short first start bit still lands.
	logic [11:0] f;
	initial begin
		frame = '1;
		n_frames = 8'h00;
		cts_n = 1'b0;
		forever begin
			@(negedge tx_pin);
			f = '1;
			repeat (bit_clks / 2) @(posedge clk);
			for (int i = 0; i < nbits; i++) begin
				if (i > 0)
					repeat (bit_clks) @(posedge clk);
				f[i] = tx_pin;
			end
			frame = f;
			n_frames = n_frames + 8'h01;
		end
	end
endmodule : serial_peer
`default_nettype wire

//--- tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
	$display("BAD %s exp %h got %h", n, e, g); end end
module tb;
	logic clk, resetn, eight_x_mode, dsr_n, cd_n, ri_n, tx_pin, cts_n, rts_n, dtr_n;
	logic [7:0] rdata, n_frames, v, lc, seen;
	logic [3:0] nbits;
	logic [4:0] bit_clks;
	logic [11:0] frame;
	logic [11:0] exp_q[$];
	logic [7:0] fmts[4] = '{8'h03, 8'h1b, 8'h0c, 8'h2a};
	uart_channel_pkg::reg_req_s req;
	uart_channel_pkg::rx_status_s rx_status;
	int failures, n_tests, cycles;
	uart_channel uart_channel_i (.clk, .resetn, .req, .rdata, .tx_space(), .eight_x_mode,
		.tx_pin, .rts_n, .dtr_n, .cts_n, .dsr_n, .cd_n, .ri_n, .rx_status, .rx_pop(),
		.rx_fifo_reset(), .sample_tick(), .loop_data(), .rx_config());
	serial_peer serial_peer_i (.clk, .tx_pin, .nbits, .bit_clks, .frame, .n_frames, .cts_n);
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles > 20000) begin
			failures++;
			summarize();
		end
	end
	task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] wd);
		@(posedge clk);
		#2 req = '{rd: !w, wr: w, addr: a, wdata: wd};
		@(posedge clk);
		#2 req = '0;
		v = rdata;
	endtask : acc
	task automatic fmt(input logic [7:0] l);
		lc = l;
		nbits = 4'd7 + l[1:0] + l[3] + l[2];
		acc(1, 4'h3, l);
	endtask : fmt
	task automatic send(input logic [7:0] d);
		logic [11:0] f;
		logic p;
		f = '1;
		f[0] = 1'b0;
		p = ^(d & (8'hff >> (3 - lc[1:0])));
		for (int k = 0; k < lc[1:0] + 5; k++)
			f[k + 1] = d[k];
		if (lc[3])
			f[lc[1:0] + 6] = lc[5] ? !lc[4] : (lc[4] ? p : !p);
		exp_q.push_back(f);
		acc(1, 4'h0, d);
	endtask : send
	task automatic drain();
		logic [11:0] ef;
		while (exp_q.size() > 0) begin
			seen = n_frames;
			for (int k = 0; k < 600 && n_frames == seen; k++)
				@(posedge clk);
			`CHK("n_frames", seen + 8'h01, n_frames)
			ef = exp_q.pop_front();
			`CHK("frame", ef, frame)
		end
		#2;
	endtask : drain
	task automatic summarize();
		$display("failures %0d n_tests %0d", failures, n_tests);
		if (failures == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize
	initial begin
		resetn = 1'b0;
		req = '0;
		rx_status = '0;
		eight_x_mode = 1'b0;
		dsr_n = 1'b1;
		cd_n = 1'b1;
		ri_n = 1'b1;
		bit_clks = 5'd16;
		nbits = 4'd10;
		void'($urandom(62));
		repeat (10) @(posedge clk);
		#2 resetn = 1'b1;
		acc(0, 4'h3, 8'h00);
		`CHK("line_control", 8'h00, v)
		lc = 8'($urandom);
		acc(1, 4'h7, lc);
		acc(0, 4'h7, 8'h00);
		`CHK("scratch", lc, v)
		acc(1, 4'h3, 8'h80);
		acc(1, 4'h0, 8'h01);
		acc(1, 4'h1, 8'h00);
		acc(0, 4'h0, 8'h00);
		`CHK("divisor_low", 8'h01, v)
		fmt(8'h03);
		rx_status.data = 8'($urandom);
		acc(0, 4'h0, 8'h00);
		`CHK("rx_holding", rx_status.data, v)
		foreach (fmts[i]) begin
			fmt(fmts[i]);
			send(8'($urandom));
			acc(0, 4'h5, 8'h00);
			`CHK("shifter empty", 1'b0, v[6])
			drain();
		end
		eight_x_mode = 1'b1;
		bit_clks = 5'd8;
		send(8'($urandom));
		drain();
		eight_x_mode = 1'b0;
		bit_clks = 5'd16;
		// Bytes are queued back to back so the FIFO, not the host, feeds the holding stage.
		acc(1, 4'h2, 8'h03);
		repeat (3) send(8'($urandom));
		drain();
		for (int k = 0; k < 40 && v[6] !== 1'b1; k++)
			acc(0, 4'h5, 8'h00);
		`CHK("line_status", 2'b11, v[6:5])
		acc(1, 4'h4, 8'h1b);
		seen = n_frames;
		acc(1, 4'h0, 8'h00);
		repeat (300) @(posedge clk);
		`CHK("loop frames", seen, n_frames)
		`CHK("rts_n", 1'b1, rts_n)
		`CHK("dtr_n", 1'b1, dtr_n)
		acc(0, 4'h6, 8'h00);
		`CHK("modem_status", 4'hb, v[7:4])
		summarize();
	end
endmodule : tb
bind uart_channel uart_channel_chk uart_channel_chk_i (.clk, .resetn, .req, .rdata,
	.tx_space, .tx_pin, .rx_pop, .rx_fifo_reset, .rx_config);
`default_nettype wire
